// file: hw/tebz_defines.svh
`ifndef TEBZ_DEFINES_SVH
`define TEBZ_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets (haddr[7:0])
// ----------------------------------------------------------------
`define TEBZ_OFF_C8_CTRL 8'h00
`define TEBZ_OFF_C8_VAL 8'h04
`define TEBZ_OFF_C16_CTRL 8'h08
`define TEBZ_OFF_C16_LOW 8'h0c
`define TEBZ_OFF_C16_HIGH 8'h10
`define TEBZ_OFF_INTC 8'h14
`define TEBZ_OFF_PORT 8'h18

// ----------------------------------------------------------------
// Interrupt control bit positions
// ----------------------------------------------------------------
`define TEBZ_INTC_EMI 0
`define TEBZ_INTC_ET0I 2
`define TEBZ_INTC_ET1I 3
`define TEBZ_INTC_T0F 5
`define TEBZ_INTC_T1F 6

// ----------------------------------------------------------------
// Port register bit positions
// ----------------------------------------------------------------
`define TEBZ_PORT_DIR0 0
`define TEBZ_PORT_DIR1 1
`define TEBZ_PORT_DAT0 2
`define TEBZ_PORT_DAT1 3
`define TEBZ_PORT_SLEEP 4

// ----------------------------------------------------------------
// Reset values, limits, vectors
// ----------------------------------------------------------------
`define TEBZ_CTRL_RST 8'h00
`define TEBZ_INTC_RST 8'h00
`define TEBZ_DIR_RST 2'h3
`define TEBZ_FULL8 16'h00ff
`define TEBZ_FULL16 16'hffff
`define TEBZ_INSTR_LAST 2'h3
`define TEBZ_PSC_TOP 3'h7
`define TEBZ_VEC_EXT 8'h04
`define TEBZ_VEC_C8 8'h08
`define TEBZ_VEC_C16 8'h0c
`define TEBZ_SYNC_W 4

`endif

// file: hw/tebz_pkg.sv
package tebz_pkg;

    typedef enum logic [1:0] {
        TEBZ_MODE_OFF = 2'h0,
        TEBZ_MODE_EVENT = 2'h1,
        TEBZ_MODE_TIMER = 2'h2,
        TEBZ_MODE_PULSE = 2'h3
    } tebz_mode_t;

    typedef struct packed {
        tebz_mode_t mode;
        logic spare;
        logic run;
        logic edge_sel;
        logic [2:0] psc;
    } tebz_ctrl_t;

    typedef enum logic [1:0] {
        TEBZ_PW_IDLE = 2'h0,
        TEBZ_PW_ARMED = 2'h1,
        TEBZ_PW_MEASURE = 2'h3
    } tebz_pw_t;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic valid;
    } tebz_req_t;

endpackage

// file: hw/tebz_sync.sv
`timescale 1ns/1ns
`include "tebz_defines.svh"

// ----------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module tebz_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`TEBZ_SYNC_W-1:0] in_i,
    output logic [`TEBZ_SYNC_W-1:0] lvl_o
);
    logic [`TEBZ_SYNC_W-1:0] s1_q;
    logic [`TEBZ_SYNC_W-1:0] s2_q;
    logic [`TEBZ_SYNC_W-1:0] s3_q;
    logic [`TEBZ_SYNC_W-1:0] lvl_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= in_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Level moves only when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_q <= '0;
        end else begin
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
        end
    end

    assign lvl_o = lvl_q;
endmodule

// file: hw/tebz_top.sv
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`include "tebz_defines.svh"

// Function
// - Both buzzer pins input: no buzzer output
// - Buzzer active only while bit0 data is one
// - Bit1 data never gates the buzzer
// - 8-bit clock passes three-bit selected prescaler
// - Pull-high on shared timer pins follows cfg_pull_i
// - Large package: dedicated timer pins, no pull
// - Timer mode: system clock, instruction clock
// - Full counter in timer mode raises interrupt
// - Pin conditions seen at next timer tick
// - Counter read or preload write inhibits clock
// - Overflow sets flag; interrupt only if enabled
// - Overflow while asleep wakes regardless of enable
// - Control bit four starts and stops counter
// - Vectors 08h, 0ch; external uses 04h
// - Counter counts from preload up to full
// - 081h: timer, divide four; 080h: timer
// - Overflow toggles buzzer, counter reloads preload
// - Second buzzer pin is inverse of first while bit0 data is one, else both low
// - Buzzer source fixed: 8-bit or 16-bit overflow
module tebz_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic counter8_input_pin_i,
    input wire logic counter16_input_pin_i,
    input wire logic [1:0] pb_in_i,
    output logic [1:0] pb_out_o,
    output logic [1:0] pb_oe_o,
    input wire logic cfg_buzzer_i,
    input wire logic cfg_buzzer_src_i,
    input wire logic [1:0] cfg_pull_i,
    input wire logic pkg48_i,
    output logic [1:0] timer_pull_o,
    output logic irq_o,
    output logic [7:0] irq_vector_o,
    output logic wake_o
);
    tebz_pkg::tebz_req_t req_q;
    tebz_pkg::tebz_ctrl_t ctrl_q [2];
    tebz_pkg::tebz_pw_t pw_q [2];
    logic [15:0] cnt_q [2];
    logic [15:0] pre_q [2];
    logic [15:0] ld_val [2];
    logic [7:0] lo_q;
    logic [7:0] intc_q;
    logic [1:0] dir_q;
    logic [1:0] dat_q;
    logic sleep_q;
    logic [7:0] psc_q;
    logic [1:0] div_q;
    logic [3:0] lvl;
    logic [1:0] prev_q;
    logic [1:0] tick;
    logic [1:0] cnt_en;
    logic [1:0] ovf;
    logic [1:0] pw_end;
    logic [1:0] inh;
    logic [1:0] wr_ctrl;
    logic [1:0] ld;
    logic rd_en;
    logic wr_en;
    logic wr_lo;
    logic wr_intc;
    logic wr_port;
    logic bz_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic [1:0] pb_out_q;
    logic [1:0] pb_oe_q;
    logic [1:0] pull_q;
    logic irq_q;
    logic [7:0] vec_q;
    logic wake_q;

    function automatic logic is_full(input logic idx, input logic [15:0] v);
        return v == (idx ? `TEBZ_FULL16 : `TEBZ_FULL8);
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0;
        if (hit(a, `TEBZ_OFF_C8_CTRL)) r = {24'h0, ctrl_q[0]};
        if (hit(a, `TEBZ_OFF_C8_VAL)) r = {24'h0, cnt_q[0][7:0]};
        if (hit(a, `TEBZ_OFF_C16_CTRL)) r = {24'h0, ctrl_q[1]};
        if (hit(a, `TEBZ_OFF_C16_LOW)) r = {24'h0, cnt_q[1][7:0]};
        if (hit(a, `TEBZ_OFF_C16_HIGH)) r = {24'h0, cnt_q[1][15:8]};
        if (hit(a, `TEBZ_OFF_INTC)) r = {24'h0, intc_q};
        if (hit(a, `TEBZ_OFF_PORT)) r = {22'h0, lvl[3:2], 3'h0, sleep_q, dat_q, dir_q};
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    tebz_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_i({pb_in_i, counter16_input_pin_i, counter8_input_pin_i}),
        .lvl_o(lvl)
    );

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    assign rd_en = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
    assign wr_en = req_q.valid & req_q.write;
    assign wr_ctrl[0] = wr_en & hit(req_q.addr, `TEBZ_OFF_C8_CTRL);
    assign wr_ctrl[1] = wr_en & hit(req_q.addr, `TEBZ_OFF_C16_CTRL);
    assign ld[0] = wr_en & hit(req_q.addr, `TEBZ_OFF_C8_VAL);
    assign ld[1] = wr_en & hit(req_q.addr, `TEBZ_OFF_C16_HIGH);
    assign wr_lo = wr_en & hit(req_q.addr, `TEBZ_OFF_C16_LOW);
    assign wr_intc = wr_en & hit(req_q.addr, `TEBZ_OFF_INTC);
    assign wr_port = wr_en & hit(req_q.addr, `TEBZ_OFF_PORT);
    assign ld_val[0] = {8'h0, hwdata_i[7:0]};
    assign ld_val[1] = {hwdata_i[7:0], lo_q};

    // Counter clock held off during value read or preload write
    assign inh[0] = (rd_en & hit(haddr_i[7:0], `TEBZ_OFF_C8_VAL)) | ld[0];
    assign inh[1] = (rd_en & (hit(haddr_i[7:0], `TEBZ_OFF_C16_LOW)
                    | hit(haddr_i[7:0], `TEBZ_OFF_C16_HIGH))) | ld[1] | wr_lo;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_q <= '0;
        end else if (hready_i) begin
            req_q.valid <= hsel_i & htrans_i[1];
            req_q.addr <= haddr_i[7:0];
            req_q.write <= hwrite_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hrdata_q <= 32'h0;
            hreadyout_q <= 1'b1;
        end else begin
            hreadyout_q <= 1'b1;
            if (rd_en) begin
                hrdata_q <= rd_mux(haddr_i[7:0]);
            end
        end
    end

    // ------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psc_q <= 8'h0;
            div_q <= 2'h0;
            prev_q <= 2'h0;
        end else begin
            psc_q <= psc_q + 8'h1;
            div_q <= div_q + 2'h1;
            prev_q <= lvl[1:0];
        end
    end

    // Prescaler period is two to the power of psc plus one
    assign tick[0] = (psc_q & (8'hff >> (`TEBZ_PSC_TOP - ctrl_q[0].psc)))
                     == (8'hff >> (`TEBZ_PSC_TOP - ctrl_q[0].psc));
    assign tick[1] = div_q == `TEBZ_INSTR_LAST;

    // ------------------------------------------------------------
    // Counter enables and overflow
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cnt_en[i] = 1'b0;
            unique case (ctrl_q[i].mode)
                tebz_pkg::TEBZ_MODE_TIMER: cnt_en[i] = tick[i];
                tebz_pkg::TEBZ_MODE_EVENT: cnt_en[i] = ctrl_q[i].edge_sel
                    ? (prev_q[i] & ~lvl[i]) : (lvl[i] & ~prev_q[i]);
                tebz_pkg::TEBZ_MODE_PULSE: cnt_en[i] = tick[i]
                    & (pw_q[i] == tebz_pkg::TEBZ_PW_MEASURE)
                    & (lvl[i] == ctrl_q[i].edge_sel);
                tebz_pkg::TEBZ_MODE_OFF: cnt_en[i] = 1'b0;
            endcase
            cnt_en[i] = cnt_en[i] & ctrl_q[i].run & ~inh[i];
            ovf[i] = cnt_en[i] & is_full(i[0], cnt_q[i]);
            pw_end[i] = ctrl_q[i].run & (ctrl_q[i].mode == tebz_pkg::TEBZ_MODE_PULSE)
                & (pw_q[i] == tebz_pkg::TEBZ_PW_MEASURE) & tick[i]
                & (lvl[i] != ctrl_q[i].edge_sel);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q[0] <= `TEBZ_CTRL_RST;
            ctrl_q[1] <= `TEBZ_CTRL_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_ctrl[i]) begin
                    ctrl_q[i] <= hwdata_i[7:0];
                end else if (pw_end[i]) begin
                    ctrl_q[i].run <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pw_q[0] <= tebz_pkg::TEBZ_PW_IDLE;
            pw_q[1] <= tebz_pkg::TEBZ_PW_IDLE;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!ctrl_q[i].run || ctrl_q[i].mode != tebz_pkg::TEBZ_MODE_PULSE) begin
                    pw_q[i] <= tebz_pkg::TEBZ_PW_IDLE;
                end else begin
                    unique case (pw_q[i])
                        tebz_pkg::TEBZ_PW_IDLE: begin
                            if (tick[i] && lvl[i] != ctrl_q[i].edge_sel) begin
                                pw_q[i] <= tebz_pkg::TEBZ_PW_ARMED;
                            end
                        end
                        tebz_pkg::TEBZ_PW_ARMED: begin
                            if (tick[i] && lvl[i] == ctrl_q[i].edge_sel) begin
                                pw_q[i] <= tebz_pkg::TEBZ_PW_MEASURE;
                            end
                        end
                        tebz_pkg::TEBZ_PW_MEASURE: begin
                            if (pw_end[i]) begin
                                pw_q[i] <= tebz_pkg::TEBZ_PW_IDLE;
                            end
                        end
                        default: pw_q[i] <= tebz_pkg::TEBZ_PW_IDLE;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Preload and count
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q[0] <= 16'h0;
            pre_q[1] <= 16'h0;
            lo_q <= 8'h0;
        end else begin
            if (wr_lo) begin
                lo_q <= hwdata_i[7:0];
            end
            for (int i = 0; i < 2; i++) begin
                if (ld[i]) begin
                    pre_q[i] <= ld_val[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q[0] <= 16'h0;
            cnt_q[1] <= 16'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ld[i] && !ctrl_q[i].run) begin
                    cnt_q[i] <= ld_val[i];
                end else if (ovf[i]) begin
                    cnt_q[i] <= pre_q[i];
                end else if (cnt_en[i]) begin
                    cnt_q[i] <= cnt_q[i] + 16'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags, request, vector, wake
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            intc_q <= `TEBZ_INTC_RST;
        end else begin
            if (wr_intc) begin
                intc_q <= hwdata_i[7:0];
            end
            // Hardware set wins over a software clear
            intc_q[`TEBZ_INTC_T0F] <= ovf[0]
                | (wr_intc ? hwdata_i[`TEBZ_INTC_T0F] : intc_q[`TEBZ_INTC_T0F]);
            intc_q[`TEBZ_INTC_T1F] <= ovf[1]
                | (wr_intc ? hwdata_i[`TEBZ_INTC_T1F] : intc_q[`TEBZ_INTC_T1F]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
            vec_q <= `TEBZ_VEC_EXT;
        end else begin
            irq_q <= intc_q[`TEBZ_INTC_EMI]
                & ((intc_q[`TEBZ_INTC_ET0I] & intc_q[`TEBZ_INTC_T0F])
                | (intc_q[`TEBZ_INTC_ET1I] & intc_q[`TEBZ_INTC_T1F]));
            vec_q <= (intc_q[`TEBZ_INTC_ET0I] & intc_q[`TEBZ_INTC_T0F])
                ? `TEBZ_VEC_C8 : `TEBZ_VEC_C16;
        end
    end

    // Flag already set suppresses the wake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= sleep_q & ((ovf[0] & ~intc_q[`TEBZ_INTC_T0F])
                | (ovf[1] & ~intc_q[`TEBZ_INTC_T1F]));
        end
    end

    // ------------------------------------------------------------
    // Port register and buzzer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q <= `TEBZ_DIR_RST;
            dat_q <= 2'h0;
            sleep_q <= 1'b0;
        end else begin
            if (wr_port) begin
                dir_q <= {hwdata_i[`TEBZ_PORT_DIR1], hwdata_i[`TEBZ_PORT_DIR0]};
                dat_q <= {hwdata_i[`TEBZ_PORT_DAT1], hwdata_i[`TEBZ_PORT_DAT0]};
                sleep_q <= hwdata_i[`TEBZ_PORT_SLEEP];
            end else if (wake_q) begin
                sleep_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bz_q <= 1'b0;
        end else if (ovf[cfg_buzzer_src_i]) begin
            bz_q <= ~bz_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pb_out_q <= 2'h0;
            pb_oe_q <= 2'h0;
            pull_q <= 2'h0;
        end else begin
            pb_oe_q <= ~dir_q;
            if (cfg_buzzer_i) begin
                pb_out_q[0] <= dat_q[0] & bz_q;
                pb_out_q[1] <= dat_q[0] & ~bz_q;
            end else begin
                pb_out_q <= dat_q;
            end
            pull_q <= pkg48_i ? 2'h0 : cfg_pull_i;
        end
    end

    assign hreadyout_o = hreadyout_q;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_q;
    assign pb_out_o = pb_out_q;
    assign pb_oe_o = pb_oe_q;
    assign timer_pull_o = pull_q;
    assign irq_o = irq_q;
    assign irq_vector_o = vec_q;
    assign wake_o = wake_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_asleep_ovf;
        sleep_q && ovf[0] && !intc_q[`TEBZ_INTC_T0F];
    endsequence

    sequence s_pulse_return;
        pw_q[0] == tebz_pkg::TEBZ_PW_MEASURE && pw_end[0] && !wr_ctrl[0];
    endsequence

    buzz_gate_off_a: assert property (cfg_buzzer_i && !dat_q[0] |=> pb_out_o == 2'h0)
        else $error("buzzer drives while gate bit low");
    no_drive_a: assert property (dir_q == 2'h3 |=> pb_oe_o == 2'h0)
        else $error("buzzer pins driven while both inputs");
    buzz_pair_a: assert property (cfg_buzzer_i && dat_q[0] |=> pb_out_o[1] == ~pb_out_o[0])
        else $error("buzzer pair not complementary");
    reload_a: assert property (ovf[0] && !ld[0] |=> cnt_q[0] == $past(pre_q[0]))
        else $error("counter did not reload preload");
    flag_set_a: assert property (ovf[1] |=> intc_q[`TEBZ_INTC_T1F])
        else $error("overflow flag not set");
    irq_gate_a: assert property (irq_o |-> $past(intc_q[`TEBZ_INTC_EMI]))
        else $error("interrupt without master enable");
    wake_a: assert property (s_asleep_ovf |=> wake_o ##1 !sleep_q)
        else $error("no wake on overflow while asleep");
    read_inhibit_a: assert property (inh[0] && !ld[0] |=> $stable(cnt_q[0]))
        else $error("counter moved during access");
    buzz_toggle_a: assert property (ovf[cfg_buzzer_src_i] |=> bz_q != $past(bz_q))
        else $error("buzzer did not toggle on overflow");
    pulse_stop_a: assert property (s_pulse_return |=> !ctrl_q[0].run ##1 !cnt_en[0])
        else $error("pulse measure did not stop");
endmodule

// file: test/tebz_pulse_src.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Event source on a timer input pin
// ----------------------------------------------------------------
module tebz_pulse_src (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [7:0] count_i,
    output logic pin_o
);
    logic [7:0] left = 8'h00;
    logic [3:0] ph = 4'h0;
    logic pin_q = 1'b0;

    assign pin_o = pin_q;

    // Pin stays a plain input level source, idle low
    always @(posedge clk_i) begin
        if (go_i) begin
            left <= count_i;
            ph <= 4'h0;
        end else if (left != 8'h00) begin
            ph <= ph + 4'h1;
            if (ph == 4'h7) begin
                ph <= 4'h0;
                pin_q <= ~pin_q;
                if (pin_q) begin
                    left <= left - 8'h01;
                end
            end
        end
    end
endmodule

// file: test/timer_event_counter_buzzer_output_tb.sv
`timescale 1ns/1ns

module timer_event_counter_buzzer_output_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic pin16 = 1'b0;
    logic [1:0] pb_in = 2'h2;
    logic cfg_src = 1'b0;
    logic pkg48 = 1'b0;
    logic go = 1'b0;
    logic pin8, hreadyout, hresp, irq, wake;
    logic [31:0] hrdata, rv;
    logic [1:0] pb_out, pb_oe, pull;
    logic [7:0] vec;
    logic last = 1'b0;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    int wakes = 0;
    int toggles = 0;
    int gap = 0;
    int run = 0;
    int n;

    always #25 clk_i = ~clk_i;

    tebz_top dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
        .counter8_input_pin_i(pin8), .counter16_input_pin_i(pin16), .pb_in_i(pb_in),
        .pb_out_o(pb_out), .pb_oe_o(pb_oe), .cfg_buzzer_i(1'b1), .cfg_buzzer_src_i(cfg_src),
        .cfg_pull_i(2'h3), .pkg48_i(pkg48), .timer_pull_o(pull), .irq_o(irq),
        .irq_vector_o(vec), .wake_o(wake));

    tebz_pulse_src src (.clk_i(clk_i), .go_i(go), .count_i(8'h05), .pin_o(pin8));

    // ----------------------------------------------------------------
    // Monitors and timeout
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (wake === 1'b1) begin
            wakes <= wakes + 1;
        end
        if (pb_out[0] !== last) begin
            last <= pb_out[0];
            gap <= run + 1;
            run <= 0;
            toggles <= toggles + 1;
        end else begin
            run <= run + 1;
        end
        if (cyc == 40000) begin
            miscompares++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge clk_i);
        while (hreadyout !== 1'b1) @(posedge clk_i);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_i);
        while (hreadyout !== 1'b1) @(posedge clk_i);
        rv = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rv, e);
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge clk_i);
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 300 && irq !== 1'b1; i++) @(negedge clk_i);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_period();
        logic [7:0] p;
        wr(8'h18, 8'h04);
        for (int i = 0; i < 4; i++) begin
            p = 8'(i);
            cfg_src <= (i == 3);
            if (i < 3) begin
                wr(8'h00, 8'h80 | p);
                wr(8'h04, 8'hf0);
                wr(8'h00, 8'h90 | p);
            end else begin
                wr(8'h00, 8'h80);
                wr(8'h08, 8'h80);
                wr(8'h0c, 8'hf0);
                wr(8'h10, 8'hff);
                wr(8'h08, 8'h90);
            end
            n = toggles;
            for (int k = 0; k < 3000 && toggles < n + 3; k++) @(negedge clk_i);
            chk(gap, (i < 3) ? (16 << (i + 1)) : 64);
            chk({31'h0, pb_out[1]}, {31'h0, ~pb_out[0]});
        end
        chk({30'h0, pb_oe}, 32'h3);
    endtask

    task automatic t_gate();
        wr(8'h18, 8'h08);
        cycles(3);
        n = toggles;
        chk({30'h0, pb_out}, 32'h0);
        cycles(200);
        chk(toggles - n, 0);
        wr(8'h18, 8'h07);
        cycles(3);
        chk({30'h0, pb_oe}, 32'h0);
    endtask

    task automatic t_irq();
        wr(8'h08, 8'h80);
        wr(8'h14, 8'h00);
        wr(8'h04, 8'hfb);
        wr(8'h00, 8'h81);
        wr(8'h00, 8'h91);
        wr(8'h14, 8'h0d);
        wait_irq();
        chk({31'h0, irq}, 32'h1);
        chk({24'h0, vec}, 32'h08);
        wr(8'h14, 8'h01);
        cycles(80);
        bus(1'b0, 8'h14, 32'h0);
        chk({31'h0, rv[5]}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(8'h00, 8'h81);
        wr(8'h14, 8'h09);
        wr(8'h08, 8'h90);
        wait_irq();
        chk({24'h0, vec}, 32'h0c);
    endtask

    task automatic t_wake();
        wr(8'h08, 8'h80);
        wr(8'h14, 8'h00);
        wr(8'h04, 8'hfb);
        wr(8'h00, 8'h91);
        n = wakes;
        wr(8'h18, 8'h17);
        cycles(200);
        chk(wakes - n, 1);
        wr(8'h14, 8'h20);
        n = wakes;
        wr(8'h18, 8'h17);
        cycles(200);
        chk(wakes - n, 0);
        wr(8'h00, 8'h81);
    endtask

    task automatic burst();
        @(posedge clk_i);
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        cycles(110);
    endtask

    task automatic t_event();
        wr(8'h00, 8'h40);
        wr(8'h04, 8'h10);
        wr(8'h00, 8'h50);
        burst();
        rd_chk(8'h04, 32'h15);
        wr(8'h00, 8'h40);
        burst();
        rd_chk(8'h04, 32'h15);
        wr(8'h00, 8'h58);
        burst();
        rd_chk(8'h04, 32'h1a);
    endtask

    // Single shot: first high pulse measured, run cleared after it
    task automatic t_pulse();
        wr(8'h00, 8'hc8);
        wr(8'h04, 8'h20);
        wr(8'h00, 8'hd8);
        burst();
        rd_chk(8'h04, 32'h23);
        rd_chk(8'h00, 32'hc8);
    endtask

    task automatic t_misc();
        chk({30'h0, pull}, 32'h3);
        pkg48 <= 1'b1;
        cycles(3);
        chk({30'h0, pull}, 32'h0);
        rd_chk(8'h1c, 32'h0);
        bus(1'b0, 8'h18, 32'h0);
        chk({30'h0, rv[9:8]}, 32'h2);
        wr(8'h04, 8'h9b);
        rd_chk(8'h04, 32'h9b);
    endtask

    initial begin
        cycles(2);
        chk({30'h0, pb_oe}, 32'h0);
        chk({30'h0, pb_out}, 32'h0);
        chk({24'h0, vec}, 32'h04);
        repeat (18) @(posedge clk_i);
        rst_i <= 1'b0;
        t_period();
        t_gate();
        t_irq();
        t_wake();
        t_event();
        t_pulse();
        t_misc();
        wrap_up();
    end
endmodule
